// >>> core/jbf_flow_unit.sv
// Purpose: Resolves jumps and conditional branches into a new program counter.
// Assumes: Decode presents one instruction per issue pulse with its program counter.
// Notes: Results appear one clock after the issue pulse and stand for one cycle.
//   Target and fault address hold their last value until they are overwritten.
//
// What this block does
// - Jump loads computed target into program counter.
// - Indirect target is pointer value, absolute.
// - Indexed target is pointer plus program counter.
// - Source is any general, stack or frame pointer.
// - Odd pointer value raises alignment exception instead.
// - Short jump adds 13-bit signed even offset.
// - Long jump adds 25-bit signed even offset.
// - Long jump is 32-bit; others 16-bit.
// - Jumps and branches never issue in parallel.
// - Branch taken when flag matches encoded sense.
// - Hint marks predicted taken; default not taken.
// - Branch offset is 11-bit signed even displacement.
// - Branch decision depends only on current flag.
// - Taken branch adds sign-extended offset to counter.
// - Branch reads the current condition code flag.
`timescale 1ns/1ps

module jbf_flow_unit (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire jbf_pkg::jbf_issue_t I_ISSUE,
  input wire jbf_pkg::jbf_ptr_file_t I_PTR,
  output jbf_pkg::jbf_flow_t O_FLOW
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    jbf_pkg::jbf_flow_t flow;
  } jbf_state_t;

  jbf_state_t state;
  jbf_state_t next_state;

  jbf_pkg::jbf_form_t form;
  logic [15:0] first_half;
  logic [15:0] second_half;
  logic [2:0] ptr_idx;
  logic [31:0] ptr_val;
  logic [jbf_pkg::ADDR_W-1:0] short_tgt;
  logic [jbf_pkg::ADDR_W-1:0] long_tgt;
  logic [jbf_pkg::ADDR_W-1:0] br_tgt;
  logic br_sense;
  logic br_hint;
  logic br_taken;

  // ********************************************************
  // Field extraction
  // ********************************************************
  assign first_half = I_ISSUE.word[31:16];
  assign second_half = I_ISSUE.word[15:0];
  // Any of the eight pointer slots is legal, stack and frame pointer included.
  assign ptr_idx = first_half[jbf_pkg::PTR_IDX_W-1:0];
  assign ptr_val = I_PTR[ptr_idx];

  assign br_sense = first_half[jbf_pkg::BR_SENSE_BIT];
  assign br_hint = first_half[jbf_pkg::BR_HINT_BIT];
  // Only the flag value presented with this issue decides the outcome.
  assign br_taken = (I_ISSUE.condition_code_flag == br_sense);

  // ********************************************************
  // Relative targets
  // ********************************************************
  // Each immediate stores the offset halved, so bit 0 of the target step is zero.
  jbf_rel_target #(
    .OFS_W(jbf_pkg::SHORT_OFS_W)
  ) u_short_target (
    .i_ofs_half(first_half[jbf_pkg::SHORT_OFS_W-1:0]),
    .i_pc(I_ISSUE.pc),
    .o_target(short_tgt)
  );

  jbf_rel_target #(
    .OFS_W(jbf_pkg::LONG_HI_W + 16)
  ) u_long_target (
    .i_ofs_half({first_half[jbf_pkg::LONG_HI_W-1:0], second_half}),
    .i_pc(I_ISSUE.pc),
    .o_target(long_tgt)
  );

  jbf_rel_target #(
    .OFS_W(jbf_pkg::BR_OFS_W)
  ) u_branch_target (
    .i_ofs_half(first_half[jbf_pkg::BR_OFS_W-1:0]),
    .i_pc(I_ISSUE.pc),
    .o_target(br_tgt)
  );

  // ********************************************************
  // Form decode
  // ********************************************************
  always_comb begin
    form = jbf_pkg::FORM_NONE;
    // The opcode fields never overlap, so at most one test below can match.
    if (first_half[15:jbf_pkg::OP_IND_LSB] == jbf_pkg::OP_INDIRECT) begin
      form = jbf_pkg::FORM_INDIRECT;
    end else if (first_half[15:jbf_pkg::OP_IND_LSB] == jbf_pkg::OP_INDEXED) begin
      form = jbf_pkg::FORM_INDEXED;
    end else if (first_half[15:jbf_pkg::OP_LONG_LSB] == jbf_pkg::OP_LONG) begin
      form = jbf_pkg::FORM_LONG;
    end else if (first_half[15:jbf_pkg::OP_SHORT_LSB] == jbf_pkg::OP_SHORT) begin
      form = jbf_pkg::FORM_SHORT;
    end else if (first_half[15:jbf_pkg::OP_SHORT_LSB] == jbf_pkg::OP_BRANCH) begin
      form = jbf_pkg::FORM_BRANCH;
    end
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    next_state = state;
    // Target and fault address are held; only the pulse fields fall back to zero.
    next_state.flow.done = 1'b0;
    next_state.flow.redirect = 1'b0;
    next_state.flow.align_exc = 1'b0;
    next_state.flow.issue_reject = 1'b0;
    next_state.flow.predict_taken = 1'b0;
    next_state.flow.mispredict = 1'b0;
    next_state.flow.is_long = 1'b0;
    // No arithmetic status is produced here and no privilege level is checked.
    if (I_ISSUE.valid && form != jbf_pkg::FORM_NONE) begin
      next_state.flow.done = 1'b1;
      next_state.flow.is_long = (form == jbf_pkg::FORM_LONG);
      if (I_ISSUE.parallel) begin
        // A flow instruction bundled with others is refused and changes nothing.
        next_state.flow.issue_reject = 1'b1;
      end else begin
        case (form)
          jbf_pkg::FORM_INDIRECT: begin
            if (ptr_val[0]) begin
              next_state.flow.align_exc = 1'b1;
              next_state.flow.fault_addr = ptr_val;
            end else begin
              next_state.flow.redirect = 1'b1;
              next_state.flow.target = ptr_val;
            end
          end
          jbf_pkg::FORM_INDEXED: begin
            // Alignment is judged on the pointer itself, not on the sum.
            if (ptr_val[0]) begin
              next_state.flow.align_exc = 1'b1;
              next_state.flow.fault_addr = ptr_val;
            end else begin
              next_state.flow.redirect = 1'b1;
              next_state.flow.target = I_ISSUE.pc + ptr_val;
            end
          end
          jbf_pkg::FORM_SHORT: begin
            next_state.flow.redirect = 1'b1;
            next_state.flow.target = short_tgt;
          end
          jbf_pkg::FORM_LONG: begin
            next_state.flow.redirect = 1'b1;
            next_state.flow.target = long_tgt;
          end
          jbf_pkg::FORM_BRANCH: begin
            next_state.flow.redirect = 1'b1;
            next_state.flow.predict_taken = br_hint;
            next_state.flow.mispredict = (br_hint != br_taken);
            if (br_taken) begin
              next_state.flow.target = br_tgt;
            end else begin
              // The fall-through address is reported as a redirect so fetch has one path.
              next_state.flow.target = I_ISSUE.pc + jbf_pkg::SEQ_STEP_16;
            end
          end
          default: begin
            next_state.flow.done = 1'b0;
          end
        endcase
      end
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      state.flow <= jbf_pkg::FLOW_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ********************************************************
  // Output
  // ********************************************************
  assign O_FLOW = state.flow;

endmodule

// ********************************************************
// Relative target adder
// ********************************************************
// Sign-extends a halved immediate, restores its zero bit 0 and adds the
// program counter. One copy serves each relative encoding.
module jbf_rel_target #(
  parameter int unsigned ADDR_W = jbf_pkg::ADDR_W,
  parameter int unsigned OFS_W = jbf_pkg::SHORT_OFS_W
) (
  input wire logic [OFS_W-1:0] i_ofs_half,
  input wire logic [ADDR_W-1:0] i_pc,
  output logic [ADDR_W-1:0] o_target
);

  logic [ADDR_W-1:0] ofs_bytes;

  assign ofs_bytes = {{(ADDR_W-OFS_W-1){i_ofs_half[OFS_W-1]}}, i_ofs_half, 1'b0};
  assign o_target = i_pc + ofs_bytes;

endmodule

// >>> core/jbf_pkg.sv
// Purpose: Shared constants and carrier types of the jump and branch flow unit.
// Assumes: Instruction words arrive with the first halfword in bits 31:16.
// Notes: Opcode values are local encodings chosen for this core.
package jbf_pkg;

  // ********************************************************
  // Widths and sizes
  // ********************************************************
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned NUM_PTR = 8;
  localparam int unsigned PTR_IDX_W = 3;
  localparam logic [31:0] SEQ_STEP_16 = 32'h0000_0002;
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;

  // ********************************************************
  // Pointer register indices
  // ********************************************************
  localparam logic [2:0] IDX_STACK_POINTER = 3'h6;
  localparam logic [2:0] IDX_FRAME_POINTER = 3'h7;

  // ********************************************************
  // Opcode fields of the first halfword
  // ********************************************************
  localparam int unsigned OP_IND_LSB = 3;
  localparam logic [12:0] OP_INDIRECT = 13'h00a0;
  localparam logic [12:0] OP_INDEXED = 13'h00a1;
  localparam int unsigned OP_SHORT_LSB = 12;
  localparam logic [3:0] OP_SHORT = 4'h2;
  localparam logic [3:0] OP_BRANCH = 4'h1;
  localparam int unsigned OP_LONG_LSB = 8;
  localparam logic [7:0] OP_LONG = 8'he2;

  // ********************************************************
  // Operand field positions
  // ********************************************************
  localparam int unsigned SHORT_OFS_W = 12;
  localparam int unsigned BR_OFS_W = 10;
  localparam int unsigned BR_SENSE_BIT = 11;
  localparam int unsigned BR_HINT_BIT = 10;
  localparam int unsigned LONG_HI_W = 8;

  // ********************************************************
  // Carrier types
  // ********************************************************
  typedef logic [NUM_PTR-1:0][ADDR_W-1:0] jbf_ptr_file_t;

  typedef struct packed {
    logic valid;
    logic parallel;
    logic [31:0] word;
    logic [ADDR_W-1:0] pc;
    logic condition_code_flag;
  } jbf_issue_t;

  typedef struct packed {
    logic done;
    logic redirect;
    logic [ADDR_W-1:0] target;
    logic align_exc;
    logic [ADDR_W-1:0] fault_addr;
    logic issue_reject;
    logic predict_taken;
    logic mispredict;
    logic is_long;
  } jbf_flow_t;

  localparam jbf_flow_t FLOW_RESET = '{
    done: 1'b0,
    redirect: 1'b0,
    target: RESET_ADDR,
    align_exc: 1'b0,
    fault_addr: RESET_ADDR,
    issue_reject: 1'b0,
    predict_taken: 1'b0,
    mispredict: 1'b0,
    is_long: 1'b0
  };

  typedef enum logic [2:0] {
    FORM_NONE,
    FORM_INDIRECT,
    FORM_INDEXED,
    FORM_SHORT,
    FORM_LONG,
    FORM_BRANCH
  } jbf_form_t;

endpackage

// >>> verification/jbf_flow_unit_props.sv
// Purpose: Port-level assertions for the jump and branch flow unit.
// Assumes: Field positions and opcodes as declared in jbf_pkg.
// Notes: Bound to every jbf_flow_unit instance.
`timescale 1ns/1ps
module jbf_flow_unit_props (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire jbf_pkg::jbf_issue_t I_ISSUE,
  input wire jbf_pkg::jbf_ptr_file_t I_PTR,
  input wire jbf_pkg::jbf_flow_t O_FLOW
);
  // ****************
  // Decode helpers
  // ****************
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  wire [31:0] w = I_ISSUE.word;
  wire [31:0] pc = I_ISSUE.pc;
  wire [31:0] ptr = I_PTR[w[18:16]];
  wire ok = I_ISSUE.valid && !I_ISSUE.parallel;
  wire ind = w[31:19] == jbf_pkg::OP_INDIRECT;
  wire idx = w[31:19] == jbf_pkg::OP_INDEXED;
  wire lng = w[31:24] == jbf_pkg::OP_LONG;
  wire sht = w[31:28] == jbf_pkg::OP_SHORT;
  wire br = w[31:28] == jbf_pkg::OP_BRANCH;
  wire flw = ind || idx || lng || sht || br;
  wire tk = I_ISSUE.condition_code_flag == w[27];
  wire [31:0] t_s = pc + {{19{w[27]}}, w[27:16], 1'b0};
  wire [31:0] t_l = pc + {{7{w[23]}}, w[23:0], 1'b0};
  wire [31:0] t_b = pc + {{21{w[25]}}, w[25:16], 1'b0};
  wire [31:0] t_p = ind ? ptr : ptr + pc;
  property p_jmp; ok && (ind || idx) && !ptr[0] |=> O_FLOW.redirect
    && O_FLOW.target == $past(t_p); endproperty
  a_jmp: assert property (p_jmp) else $error("pointer jump target");
  property p_aln; ok && (ind || idx) && ptr[0] |=> O_FLOW.align_exc && !O_FLOW.redirect
    && O_FLOW.fault_addr == $past(ptr); endproperty
  a_aln: assert property (p_aln) else $error("odd pointer");
  property p_sht; ok && sht |=> O_FLOW.redirect && O_FLOW.target == $past(t_s); endproperty
  a_sht: assert property (p_sht) else $error("short target");
  property p_lng; ok && lng |=> O_FLOW.is_long && O_FLOW.target == $past(t_l); endproperty
  a_lng: assert property (p_lng) else $error("long target");
  property p_brt; ok && br && tk |=> O_FLOW.target == $past(t_b); endproperty
  a_brt: assert property (p_brt) else $error("taken branch");
  property p_brn; ok && br && !tk |=> O_FLOW.target == $past(pc) + 32'h2; endproperty
  a_brn: assert property (p_brn) else $error("untaken branch");
  property p_hnt; ok && br |=> O_FLOW.predict_taken == $past(w[26])
    && O_FLOW.mispredict == ($past(w[26]) != $past(tk)); endproperty
  a_hnt: assert property (p_hnt) else $error("prediction flags");
  property p_rej; I_ISSUE.valid && I_ISSUE.parallel && flw |=> O_FLOW.done
    && O_FLOW.issue_reject && !O_FLOW.redirect && !O_FLOW.align_exc; endproperty
  a_rej: assert property (p_rej) else $error("parallel issue");
  property p_one; !(I_ISSUE.valid && I_ISSUE.parallel) |=> !O_FLOW.issue_reject; endproperty
  a_one: assert property (p_one) else $error("reject without parallel issue");
  property p_don; ok && flw |=> O_FLOW.done && !O_FLOW.issue_reject; endproperty
  a_don: assert property (p_don) else $error("flow instruction not handled");
  property p_idl; !I_ISSUE.valid |=> !O_FLOW.done && !O_FLOW.redirect
    && !O_FLOW.align_exc; endproperty
  a_idl: assert property (p_idl) else $error("activity without issue");
  cover property (O_FLOW.align_exc);
  cover property (ok && br && tk && w[26]);
  cover property (O_FLOW.issue_reject);
  cover property (O_FLOW.mispredict);
endmodule
bind jbf_flow_unit jbf_flow_unit_props u_props (.I_MCLK(I_MCLK), .I_SRST(I_SRST),
  .I_ISSUE(I_ISSUE), .I_PTR(I_PTR), .O_FLOW(O_FLOW));

// >>> verification/jbf_ptr_model.sv
// Purpose: Pointer register file of the core feeding the flow unit.
// Assumes: Bench writes one register per clock.
// Notes: A register reads unknown until first written.
`timescale 1ns/1ps
module jbf_ptr_model (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [2:0] i_idx,
  input wire logic [31:0] i_val,
  output jbf_pkg::jbf_ptr_file_t o_ptr
);
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      o_ptr[i_idx] <= i_val;
    end
  end
endmodule

// >>> verification/jbf_flow_unit_tb_top.sv
// Purpose: Self-checking bench for the jump and branch flow unit.
// Assumes: Results stand one cycle after the issue edge.
// Notes: Each go call leaves one idle cycle between issues.
`timescale 1ns/1ps
module jbf_flow_unit_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pw = 1'b0;
  logic [2:0] pi = 3'h0;
  logic [31:0] pv = 32'h0;
  jbf_pkg::jbf_issue_t iss = '0;
  jbf_pkg::jbf_ptr_file_t ptr;
  jbf_pkg::jbf_flow_t fl;
  int error_cnt = 0;
  int tests_run = 0;
  jbf_ptr_model pm (.i_clk(clk), .i_we(pw), .i_idx(pi), .i_val(pv), .o_ptr(ptr));
  jbf_flow_unit dut (.I_MCLK(clk), .I_SRST(rst), .I_ISSUE(iss), .I_PTR(ptr), .O_FLOW(fl));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [31:0] w, input logic [31:0] pc, input logic f, input logic p);
    @(posedge clk);
    iss <= '{1'b1, p, w, pc, f};
    @(posedge clk);
    iss.valid <= 1'b0;
    #1;
  endtask
  task automatic wp(input logic [2:0] i, input logic [31:0] v);
    @(posedge clk);
    pw <= 1'b1;
    pi <= i;
    pv <= v;
    @(posedge clk);
    pw <= 1'b0;
  endtask
  task automatic t_ptr;
    for (int i = 0; i < 8; i++) begin
      wp(i[2:0], {8'h0, i[7:0], 16'h0040});
      go({13'h00a0, i[2:0], 16'h0}, 32'h100, 1'b0, 1'b0);
      chk(fl.target, {8'h0, i[7:0], 16'h0040});
      go({13'h00a1, i[2:0], 16'h0}, 32'h100, 1'b0, 1'b0);
      chk(fl.target, {8'h0, i[7:0], 16'h0140});
      chk(fl.redirect, 1'b1);
    end
    wp(3'h6, 32'h0000_0103);
    for (int k = 0; k < 2; k++) begin
      go({12'h050, k[0], 3'h6, 16'h0}, 32'h100, 1'b0, 1'b0);
      chk({fl.align_exc, fl.redirect}, 2'h2);
      chk(fl.fault_addr, 32'h0000_0103);
    end
    $display("t_ptr done");
  endtask
  task automatic t_rel;
    go({4'h2, 12'h7ff, 16'h0}, 32'h2000, 1'b0, 1'b0);
    chk(fl.target, 32'h2ffe);
    go({4'h2, 12'h800, 16'h0}, 32'h2000, 1'b0, 1'b0);
    chk(fl.target, 32'h1000);
    go({8'he2, 24'h7fffff}, 32'h100, 1'b0, 1'b0);
    chk(fl.target, 32'h0100_00fe);
    go({8'he2, 24'h800000}, 32'h0100_0100, 1'b0, 1'b0);
    chk(fl.target, 32'h100);
    chk(fl.is_long, 1'b1);
    chk(fl.done, 1'b1);
    $display("t_rel done");
  endtask
  task automatic t_br;
    logic tk;
    for (int k = 0; k < 8; k++) begin
      tk = k[0] == k[2];
      go({4'h1, k[2], k[1], k[2] ? 10'h200 : 10'h1ff, 16'h0}, 32'h800, k[0], 1'b0);
      chk(fl.target, tk ? (k[2] ? 32'h400 : 32'hbfe) : 32'h802);
      chk({fl.redirect, fl.predict_taken}, {1'b1, k[1]});
      chk(fl.mispredict, k[1] != tk);
    end
    $display("t_br done");
  endtask
  task automatic t_rej;
    go({4'h2, 12'h010, 16'h0}, 32'h100, 1'b0, 1'b1);
    chk({fl.issue_reject, fl.redirect}, 2'h2);
    go({8'he2, 24'h10}, 32'h100, 1'b0, 1'b1);
    chk({fl.issue_reject, fl.is_long, fl.redirect}, 3'h6);
    $display("t_rej done");
  endtask
  task automatic end_sim;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_ptr;
    t_rel;
    t_br;
    t_rej;
    end_sim;
  end
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
